// ===== verilog/scstg_pkg.sv
// Constants and types for the target-side parallel bus port
package scstg_pkg;

    ////////////////////////////////////////////////////////////////////
    // Clock and bus timing
    localparam int CLK_NS    = 8;
    localparam int SETTLE_NS = 400;
    localparam int FREE_NS   = 800;
    localparam int SET_NS    = 1800;
    localparam int ARB_NS    = 2400;
    localparam int CLEAR_NS  = 800;
    // Least times round up, the SET_NS upper limit rounds down
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int FREE_CYC   = (FREE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SET_CYC    = SET_NS / CLK_NS;
    localparam int ARB_CYC    = (ARB_NS + CLK_NS - 1) / CLK_NS;
    localparam int WON_CYC    = (CLEAR_NS + SETTLE_NS + CLK_NS - 1) / CLK_NS;

    ////////////////////////////////////////////////////////////////////
    // Data bus layout
    localparam int DB_W    = 8;
    localparam int PAR_BIT = 8;
    localparam int ID_W    = 3;
    localparam int CNT_W   = 10;

    ////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic bsy;
        logic sel;
        logic cd;
        logic io;
        logic msg;
        logic req;
        logic ack;
        logic atn;
        logic rst;
    } scstg_ctl_t;

    typedef struct packed {
        logic cd;
        logic io;
        logic msg;
    } scstg_phase_t;

    typedef enum logic [7:0] {
        S_FREE  = 8'h01,
        S_ARB   = 8'h02,
        S_WON   = 8'h04,
        S_RESEL = 8'h08,
        S_SELD  = 8'h10,
        S_XFER  = 8'h20,
        S_REQ   = 8'h40,
        S_ACKW  = 8'h80
    } scstg_state_t;

endpackage

// ===== verilog/scstg_target.sv
// Target-only bus port: arbitration, (re)selection, REQ/ACK transfers
//
// Operation
// RULE1: The port acts only as target; it never selects, never drives ACK or ATN.
// RULE2: Every byte moves with a REQ/ACK handshake.
// RULE3: Every line is low true; low means asserted.
// RULE4: Only the target drives C/D; true means control, false means data.
// RULE5: Only the target drives I/O; true means toward initiator, marks reselection.
// RULE6: The target asserts MSG in message in and message out phases.
// RULE7: Target drives REQ per transfer; initiator answers with ACK.
// RULE8: Only the initiator drives ATN, to signal attention.
// RULE9: Eight data bits plus parity; bit 7 highest priority, bit 0 lowest.
// RULE10: A data bit is one when its line is asserted.
// RULE11: Parity makes the nine lines carry odd parity.
// RULE12: Parity is system wide: all generate and check, or none check.
// RULE13: Parity is not checked during arbitration.
// RULE14: Parity line is never driven false during arbitration.
// RULE15: Any asserting driver makes a line true; negating is not releasing.
// RULE16: BSY and RST are OR-tied; other lines have a single driver.
// RULE17: A device that is not the active source holds its driver released.
// RULE18: Any device may assert RST at any time.
// RULE19: In bus free every device releases every line.
// RULE20: Arbitration drives BSY and own ID bit only; only the winner drives SEL.
// RULE21: Selection and reselection lines are driven by their defined owners.
// RULE22: In transfer phases target drives BSY, C/D, I/O, MSG, REQ and inbound data.
// RULE23: On losing arbitration release all lines at once, not waiting for SEL.
// RULE24: With parity enabled flag each received even-parity byte outside arbitration.
// RULE25: Bus inputs are sampled on the clock and turned into true-high levels.
`timescale 1ns/1ps

module scstg_target
    import scstg_pkg::*;
#(
    parameter int ARB_W = CNT_W
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rstn,
    // Bus pins, active low; driver enables ctl_oe and db_oe active high
    input  wire scstg_ctl_t         ctl_in_n,
    input  wire logic [PAR_BIT:0]   db_in_n,
    output scstg_ctl_t              ctl_out_n,
    output scstg_ctl_t              ctl_oe,
    output logic [PAR_BIT:0]        db_out_n,
    output logic [PAR_BIT:0]        db_oe,
    // Controller requests
    input  wire logic [ID_W-1:0]    my_id,
    input  wire logic               parity_en,
    input  wire logic               arb_req,
    input  wire logic [ID_W-1:0]    resel_id,
    input  wire logic               xfer_go,
    input  wire scstg_phase_t       phase,
    input  wire logic [DB_W-1:0]    tx_data,
    input  wire logic               release_bus,
    input  wire logic               rst_assert,
    // Controller status
    output logic                    connected,
    output logic                    xfer_done,
    output logic [DB_W-1:0]         rx_data,
    output logic                    par_err,
    output logic                    arb_lost,
    output logic                    bus_rst,
    output logic                    atn_seen
);

    ////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [DB_W-1:0] id_bit(input logic [ID_W-1:0] id);
        id_bit = 8'h01 << id;
    endfunction

    function automatic logic [DB_W-1:0] higher(input logic [ID_W-1:0] id);
        logic [DB_W-1:0] b;
        b = id_bit(id);
        higher = ~((b << 1) - 8'h01);
    endfunction

    function automatic logic odd_par(input logic [DB_W-1:0] d);
        odd_par = ~^d;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Input sampling, low-true lines become true-high
    scstg_ctl_t          ctl_s;
    logic [PAR_BIT:0]    db_s;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctl_s <= '0;
            db_s  <= '0;
        end else begin
            ctl_s <= ~ctl_in_n;                                 // RULE25 RULE3 RULE10
            db_s  <= ~db_in_n;                                  // RULE25 RULE10
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Bus free detection and arbitration window
    logic [CNT_W-1:0]    free_cnt_r;
    logic [CNT_W-1:0]    free_cnt_nxt;
    logic [ARB_W-1:0]    tmr_r;
    logic [ARB_W-1:0]    tmr_nxt;
    scstg_state_t        state_r;
    scstg_state_t        state_nxt;
    scstg_phase_t        phase_r;
    scstg_phase_t        phase_nxt;
    logic [DB_W-1:0]     tx_r;
    logic [DB_W-1:0]     tx_nxt;
    logic                arb_pend_r;

    wire quiet      = !ctl_s.bsy && !ctl_s.sel;
    wire free_max   = &free_cnt_r;
    assign free_cnt_nxt = !quiet ? '0 : (free_max ? free_cnt_r : free_cnt_r + 1'b1);
    wire arb_open   = free_cnt_r >= CNT_W'(SETTLE_CYC + FREE_CYC)
                   && free_cnt_r <= CNT_W'(SETTLE_CYC + SET_CYC);
    wire arb_done   = tmr_r >= ARB_W'(ARB_CYC);
    wire won_done   = tmr_r >= ARB_W'(WON_CYC);
    wire hi_seen    = |(db_s[DB_W-1:0] & higher(my_id));        // RULE9
    wire par_ok     = !parity_en || ^db_s;                      // RULE11 RULE12
    wire sel_me     = ctl_s.sel && !ctl_s.bsy && !ctl_s.io
                   && |(db_s[DB_W-1:0] & id_bit(my_id));        // RULE5
    wire arb_lose   = state_r == S_ARB && (ctl_s.sel || (arb_done && hi_seen));
    wire arb_win    = state_r == S_ARB && !ctl_s.sel && arb_done && !hi_seen;
    wire conn       = state_r == S_XFER || state_r == S_REQ || state_r == S_ACKW
                   || state_r == S_SELD;
    wire take_rx    = state_r == S_REQ && ctl_s.ack && !phase_r.io;
    wire sel_chk    = state_r == S_FREE && sel_me;

    ////////////////////////////////////////////////////////////////////
    // Phase sequencing
    always_comb begin
        state_nxt = state_r;
        phase_nxt = phase_r;
        tx_nxt    = tx_r;
        unique case (state_r)
            S_FREE: begin
                if (sel_me && par_ok) begin
                    state_nxt = S_SELD;                         // RULE1
                end else if (arb_pend_r && arb_open) begin
                    state_nxt = S_ARB;
                end
            end
            S_ARB: begin
                if (arb_lose) begin
                    state_nxt = S_FREE;                         // RULE23
                end else if (arb_win) begin
                    state_nxt = S_WON;
                end
            end
            S_WON: begin
                if (won_done) begin
                    state_nxt = S_RESEL;
                end
            end
            S_RESEL: begin
                // The first sample still holds our own BSY from the won state
                if (ctl_s.bsy && tmr_r != '0) begin
                    state_nxt = S_XFER;                         // RULE21
                end
            end
            S_SELD: begin
                if (!ctl_s.sel) begin
                    state_nxt = S_XFER;
                end
            end
            S_XFER: begin
                if (xfer_go) begin
                    state_nxt = S_REQ;                          // RULE2
                    phase_nxt = phase;
                    tx_nxt    = tx_data;
                end
            end
            S_REQ: begin
                if (ctl_s.ack) begin
                    state_nxt = S_ACKW;                         // RULE7
                end
            end
            S_ACKW: begin
                if (!ctl_s.ack) begin
                    state_nxt = S_XFER;
                end
            end
        endcase
        if (release_bus && state_r != S_FREE) begin
            state_nxt = S_FREE;
        end
        if (ctl_s.rst) begin
            state_nxt = S_FREE;                                 // RULE18
        end
    end

    assign tmr_nxt = (state_nxt != state_r || &tmr_r) ? '0 : tmr_r + 1'b1;

    ////////////////////////////////////////////////////////////////////
    // Driver enables, derived from the next state
    wire n_conn = state_nxt == S_XFER || state_nxt == S_REQ || state_nxt == S_ACKW;
    wire n_arb  = state_nxt == S_ARB || state_nxt == S_WON;
    wire n_xin  = state_nxt == S_REQ && phase_nxt.io;
    wire [DB_W-1:0] rs_byte = id_bit(my_id) | id_bit(resel_id);

    scstg_ctl_t          oe_nxt;
    logic [PAR_BIT:0]    db_oe_nxt;

    always_comb begin
        oe_nxt     = '0;                                        // RULE17 RULE19
        oe_nxt.bsy = n_arb || n_conn || state_nxt == S_SELD;    // RULE16 RULE22
        oe_nxt.sel = state_nxt == S_WON || state_nxt == S_RESEL;// RULE20 RULE21
        oe_nxt.io  = state_nxt == S_RESEL || (n_conn && phase_nxt.io); // RULE5
        oe_nxt.cd  = n_conn && phase_nxt.cd;                    // RULE4
        oe_nxt.msg = n_conn && phase_nxt.msg;                   // RULE6
        oe_nxt.req = state_nxt == S_REQ;                        // RULE7
        oe_nxt.rst = rst_assert;                                // RULE18 RULE16
        db_oe_nxt  = '0;
        if (n_arb) begin
            db_oe_nxt[DB_W-1:0] = id_bit(my_id);                // RULE20 RULE14
        end else if (state_nxt == S_RESEL) begin
            db_oe_nxt = {odd_par(rs_byte), rs_byte};            // RULE11
        end else if (n_xin) begin
            db_oe_nxt = {odd_par(tx_nxt), tx_nxt};              // RULE11 RULE22
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State and pin registers
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_r    <= S_FREE;
            phase_r    <= '0;
            tx_r       <= '0;
            tmr_r      <= '0;
            free_cnt_r <= '0;
            arb_pend_r <= 1'b0;
            ctl_oe     <= '0;
            db_oe      <= '0;
            ctl_out_n  <= '0;
            db_out_n   <= '0;
        end else begin
            state_r    <= state_nxt;
            phase_r    <= phase_nxt;
            tx_r       <= tx_nxt;
            tmr_r      <= tmr_nxt;
            free_cnt_r <= free_cnt_nxt;
            arb_pend_r <= arb_req || (arb_pend_r && !arb_lose && !arb_win);
            ctl_oe     <= oe_nxt;
            db_oe      <= db_oe_nxt;
            ctl_out_n  <= '0;                                   // RULE15 RULE3
            db_out_n   <= '0;                                   // RULE15
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Status to the controller
    always_ff @(posedge clk) begin
        if (!rstn) begin
            connected <= 1'b0;
            xfer_done <= 1'b0;
            rx_data   <= '0;
            par_err   <= 1'b0;
            arb_lost  <= 1'b0;
            bus_rst   <= 1'b0;
            atn_seen  <= 1'b0;
        end else begin
            connected <= conn;
            xfer_done <= state_r == S_ACKW && !ctl_s.ack;
            if (take_rx) begin
                rx_data <= db_s[DB_W-1:0];
            end
            par_err   <= parity_en && (take_rx || sel_chk) && !(^db_s); // RULE24 RULE13
            arb_lost  <= arb_lose;
            bus_rst   <= ctl_s.rst;
            atn_seen  <= ctl_s.atn;                             // RULE8
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    never_initiator_a: assert property (  // RULE1
        @(posedge clk) disable iff (!rstn)
        !ctl_oe.ack && !ctl_oe.atn)
        else $error("ACK or ATN driven by target");

    only_assert_a: assert property (  // RULE15
        @(posedge clk) disable iff (!rstn)
        ctl_oe != '0 |-> ctl_out_n == '0)
        else $error("line driven false");

    arb_parity_a: assert property (  // RULE14
        @(posedge clk) disable iff (!rstn)
        (state_r == S_ARB) |-> !db_oe[PAR_BIT] && $onehot(db_oe))
        else $error("arbitration drive wrong");

    odd_parity_a: assert property (  // RULE11
        @(posedge clk) disable iff (!rstn)
        db_oe[PAR_BIT] |-> ^db_oe)
        else $error("driven parity not odd");

    rst_release_a: assert property (  // RULE19
        @(posedge clk) disable iff (!rstn)
        ctl_s.rst |=> db_oe == '0 && !ctl_oe.bsy && !ctl_oe.req && !ctl_oe.sel)
        else $error("lines held after reset seen");

    lose_release_a: assert property (  // RULE23
        @(posedge clk) disable iff (!rstn)
        arb_lose |=> db_oe == '0 && !ctl_oe.bsy && !ctl_oe.sel && arb_lost)
        else $error("lost arbitration not released");

    req_hold_a: assert property (  // RULE7
        @(posedge clk) disable iff (!rstn)
        ctl_oe.req && !ctl_s.ack && !ctl_s.rst && !release_bus |=> ctl_oe.req)
        else $error("REQ dropped before ACK");

    par_flag_a: assert property (  // RULE24
        @(posedge clk) disable iff (!rstn)
        take_rx && parity_en && !(^db_s) |=> par_err)
        else $error("even parity byte not flagged");

    sel_bsy_a: assert property (  // RULE21
        @(posedge clk) disable iff (!rstn)
        state_r == S_FREE && sel_me && par_ok && !ctl_s.rst |=> ctl_oe.bsy && !ctl_oe.io)
        else $error("selection not answered with BSY");

    free_release_a: assert property (  // RULE19
        @(posedge clk) disable iff (!rstn)
        state_r == S_FREE |-> db_oe == '0 && !ctl_oe.bsy && !ctl_oe.sel && !ctl_oe.req)
        else $error("line driven in bus free");

    arb_drive_a: assert property (  // RULE20
        @(posedge clk) disable iff (!rstn)
        state_r == S_ARB |-> ctl_oe.bsy && !ctl_oe.sel && !ctl_oe.req)
        else $error("arbitration control lines wrong");

    phase_bsy_a: assert property (  // RULE22
        @(posedge clk) disable iff (!rstn)
        ctl_oe.cd || ctl_oe.msg || ctl_oe.req |-> ctl_oe.bsy)
        else $error("phase lines driven without BSY");

    out_data_a: assert property (  // RULE17
        @(posedge clk) disable iff (!rstn)
        state_r == S_REQ && !phase_r.io |-> db_oe == '0)
        else $error("data driven in outbound phase");

    arb_no_perr_a: assert property (  // RULE13
        @(posedge clk) disable iff (!rstn)
        state_r == S_ARB |=> !par_err)
        else $error("parity flagged in arbitration");

    resel_own_bsy_a: assert property (  // RULE21
        @(posedge clk) disable iff (!rstn)
        state_r == S_RESEL && tmr_r == '0 && !release_bus && !ctl_s.rst |=> state_r == S_RESEL)
        else $error("reselection ended on own BSY");

endmodule

// ===== tb/scstg_host.sv
// Initiator-side bus model facing the target port
`timescale 1ns/1ps

module scstg_host
    import scstg_pkg::*;
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rstn,
    // Bus lines, true-high view
    input  wire scstg_ctl_t   bus_ctl,
    input  wire logic [8:0]   bus_db,
    output scstg_ctl_t        h_ctl,
    output logic [8:0]        h_db,
    // Bench controls
    input  wire logic         sel_go,
    input  wire logic         arb_on,
    input  wire logic         atn_on,
    input  wire logic         rst_on,
    input  wire logic         bad_par,
    input  wire logic [7:0]   sel_ids,
    input  wire logic [7:0]   out_byte,
    input  wire logic [3:0]   ack_dly,
    output logic [7:0]        got_byte
);
    logic       ack_r;
    logic [3:0] wait_r;
    wire        drv_out = bus_ctl.req && !bus_ctl.io;

    ////////////////////////////////////////////////////////////////////
    // Acknowledge each request after a chosen delay
    always_ff @(posedge clk) begin
        if (!rstn || !bus_ctl.req) begin
            ack_r  <= 1'b0;
            wait_r <= 4'h0;
        end else if (!ack_r && wait_r == ack_dly) begin
            ack_r    <= 1'b1;
            got_byte <= bus_db[7:0];
        end else if (!ack_r) begin
            wait_r <= wait_r + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Released lines read false through the terminators
    always_comb begin
        h_ctl     = '0;
        h_ctl.bsy = arb_on;
        h_ctl.sel = sel_go;
        h_ctl.ack = ack_r;
        h_ctl.atn = atn_on;
        h_ctl.rst = rst_on;
    end

    // Own ID 7 in arbitration, parity left undriven
    assign h_db = sel_go ? {~^sel_ids, sel_ids} :
                  arb_on ? 9'h080 :
                  drv_out ? {(~^out_byte) ^ bad_par, out_byte} : 9'h000;
endmodule

// ===== tb/scstg_target_tb.sv
// Self-checking bench for the target bus port
`timescale 1ns/1ps

module scstg_target_tb
    import scstg_pkg::*;
;
    typedef struct packed {
        scstg_phase_t ph;
        logic [7:0]   d;
        logic [3:0]   dly;
    } scstg_row_t;

    logic         clk = 1'b0;
    logic         rstn = 1'b0;
    logic         parity_en = 1'b1;
    logic         arb_req = 1'b0;
    logic         xfer_go = 1'b0;
    logic         release_bus = 1'b0;
    logic         rst_assert = 1'b0;
    scstg_phase_t phase = '0;
    logic [7:0]   tx_data = 8'h00;
    logic         sel_go = 1'b0;
    logic         arb_on = 1'b0;
    logic         atn_on = 1'b0;
    logic         rst_on = 1'b0;
    logic         bad_par = 1'b0;
    logic [7:0]   out_byte = 8'h00;
    logic [3:0]   ack_dly = 4'h0;
    scstg_ctl_t   ctl_out_n, ctl_oe, h_ctl, bus_ctl;
    logic [8:0]   db_out_n, db_oe, h_db, bus_db;
    logic         connected, xfer_done, par_err, arb_lost, bus_rst, atn_seen;
    logic [7:0]   rx_data, got_byte;
    int           fails = 0, num_checks = 0, perr_cnt = 0, n, pe0;
    // Six phases: data out, data in, command, status, message out, message in
    scstg_row_t   rows [6] = '{'{3'b000, 8'h00, 4'h0}, '{3'b010, 8'hff, 4'h0},
        '{3'b100, 8'h81, 4'h3}, '{3'b110, 8'h7e, 4'h1}, '{3'b101, 8'h01, 4'h7},
        '{3'b111, 8'ha5, 4'h2}};

    always #4 clk = ~clk;
    // Wired bus: any asserting driver pulls the line true
    assign bus_ctl = (ctl_oe & ~ctl_out_n) | h_ctl;
    assign bus_db  = (db_oe & ~db_out_n) | h_db;
    always @(posedge clk) if (par_err === 1'b1) perr_cnt <= perr_cnt + 1;

    scstg_target dut_u (.clk(clk), .rstn(rstn), .ctl_in_n(scstg_ctl_t'(~bus_ctl)),
        .db_in_n(~bus_db), .ctl_out_n(ctl_out_n), .ctl_oe(ctl_oe), .db_out_n(db_out_n),
        .db_oe(db_oe), .my_id(3'h3), .parity_en(parity_en), .arb_req(arb_req),
        .resel_id(3'h5), .xfer_go(xfer_go), .phase(phase), .tx_data(tx_data),
        .release_bus(release_bus), .rst_assert(rst_assert), .connected(connected),
        .xfer_done(xfer_done), .rx_data(rx_data), .par_err(par_err),
        .arb_lost(arb_lost), .bus_rst(bus_rst), .atn_seen(atn_seen));

    scstg_host host_u (.clk(clk), .rstn(rstn), .bus_ctl(bus_ctl), .bus_db(bus_db),
        .h_ctl(h_ctl), .h_db(h_db), .sel_go(sel_go), .arb_on(arb_on), .atn_on(atn_on),
        .rst_on(rst_on), .bad_par(bad_par), .sel_ids(8'h88), .out_byte(out_byte),
        .ack_dly(ack_dly), .got_byte(got_byte));

    ////////////////////////////////////////////////////////////////////
    task automatic tick;
        @(posedge clk);
        #1;
    endtask

    task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic do_byte(input scstg_phase_t ph, input logic [7:0] d, input logic [3:0] dly);
        @(posedge clk);
        xfer_go  <= 1'b1;
        phase    <= ph;
        tx_data  <= d;
        out_byte <= d;
        ack_dly  <= dly;
        @(posedge clk);
        xfer_go <= 1'b0;
        #1;
        for (n = 0; n < 20 && ctl_oe.req !== 1'b1; n++) tick();
        chk("req", 9'h001, ctl_oe.req);
        chk("phase", {6'h00, ph}, {ctl_oe.cd, ctl_oe.io, ctl_oe.msg});
        chk("data oe", ph.io ? {~^d, d} : 9'h000, db_oe);
        chk("ack atn oe", 9'h000, {ctl_oe.ack, ctl_oe.atn, ctl_oe.sel});
        chk("drive low", 9'h000, ctl_out_n | db_out_n);
        for (n = 0; n < 60 && xfer_done !== 1'b1; n++) tick();
        chk("done", 9'h001, xfer_done);
        chk("byte", d, ph.io ? got_byte : rx_data);
    endtask

    // Arbitrate and check only the own ID bit is driven
    task automatic go_arb;
        @(posedge clk);
        arb_req <= 1'b1;
        @(posedge clk);
        arb_req <= 1'b0;
        #1;
        for (n = 0; n < 400 && ctl_oe.bsy !== 1'b1; n++) tick();
        chk("arb bsy", 9'h001, ctl_oe.bsy);
        chk("arb id", 9'h008, db_oe);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        #(CLK_NS * 20000);
        fails++;
        give_verdict();
    end

    initial begin
        repeat (20) tick();
        chk("oe in reset", 9'h000, ctl_oe | db_oe);
        chk("status", 9'h000, {connected, xfer_done, par_err, arb_lost, bus_rst, atn_seen});
        @(posedge clk);
        rstn   <= 1'b1;
        sel_go <= 1'b1;
        #1;
        for (n = 0; n < 50 && connected !== 1'b1; n++) tick();
        chk("connected", 9'h001, connected);
        chk("bsy answer", 9'h001, ctl_oe.bsy);
        @(posedge clk);
        sel_go <= 1'b0;
        atn_on <= 1'b1;
        repeat (4) tick();
        chk("atn seen", 9'h001, atn_seen);
        @(posedge clk);
        atn_on <= 1'b0;
        foreach (rows[i]) do_byte(rows[i].ph, rows[i].d, rows[i].dly);
        pe0 = perr_cnt;
        bad_par <= 1'b1;
        do_byte(3'b000, 8'h3c, 4'h1);
        chk("par err", 9'h001, 9'(perr_cnt - pe0));
        parity_en <= 1'b0;
        do_byte(3'b100, 8'h5a, 4'h0);
        chk("par off", 9'h001, 9'(perr_cnt - pe0));
        bad_par   <= 1'b0;
        parity_en <= 1'b1;
        @(posedge clk);
        rst_on <= 1'b1;
        #1;
        for (n = 0; n < 100 && connected !== 1'b0; n++) tick();
        chk("rst drops link", 9'h000, connected);
        repeat (3) tick();
        chk("rst seen", 9'h001, bus_rst);
        chk("rst release", 9'h000, ctl_oe | db_oe);
        @(posedge clk);
        rst_on <= 1'b0;
        go_arb();
        for (n = 0; n < 700 && ctl_oe.io !== 1'b1; n++) tick();
        chk("resel lines", 9'h006, {ctl_oe.sel, ctl_oe.io, ctl_oe.bsy});
        chk("resel ids", {~^8'h28, 8'h28}, db_oe);
        repeat (3) tick();
        chk("resel waits", 9'h000, connected);
        @(posedge clk);
        arb_on <= 1'b1;
        #1;
        for (n = 0; n < 10 && connected !== 1'b1; n++) tick();
        chk("resel answer", 9'h003, {ctl_oe.sel, ctl_oe.bsy, connected});
        @(posedge clk);
        arb_on      <= 1'b0;
        release_bus <= 1'b1;
        @(posedge clk);
        release_bus <= 1'b0;
        repeat (3) tick();
        chk("bus free", 9'h000, ctl_oe | db_oe);
        pe0 = perr_cnt;
        go_arb();
        @(posedge clk);
        arb_on <= 1'b1;
        #1;
        for (n = 0; n < 400 && arb_lost !== 1'b1; n++) tick();
        chk("arb lost", 9'h001, arb_lost);
        repeat (2) tick();
        chk("loser released", 9'h000, ctl_oe | db_oe);
        chk("no arb parity", 9'h000, 9'(perr_cnt - pe0));
        @(posedge clk);
        arb_on     <= 1'b0;
        rst_assert <= 1'b1;
        tick();
        chk("rst drive", 9'h001, ctl_oe.rst);
        repeat (2) tick();
        chk("own rst seen", 9'h001, bus_rst);
        @(posedge clk);
        rst_assert <= 1'b0;
        give_verdict();
    end
endmodule
